/* File: agu_addr_mod.sv */
// Address modification for the X data path: modulo and bit reversal.
// Assumes the core presents one access per cycle and keeps the pointer
// file; this block only computes the effective address and write back.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Modulo correction for any working pointer
// - Wrap only on passing bounds, reaching end does not wrap
// - Write back only for pre/post modify
// - Bit reversal on X side writes only
// - Only modifier treated as bit reversed
// - Needs select not 1111, enable, increment
// - Fifteen bit pivot, enable in msb
// - Word data, lsb clear, pivot scaled
// - Byte or other modes give normal addresses
// - Pointer plus pivot, mode offset ignored
module agu_addr_mod (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Register port
   input wire logic [3:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [15:0] o_reg_rdata,
   // Access request from the core
   input wire logic i_acc_valid,
   input wire logic i_acc_xside,
   input wire logic i_acc_write,
   input wire logic i_acc_byte,
   input wire logic [2:0] i_acc_mode,
   input wire logic [3:0] i_acc_ptr_sel,
   input wire logic [15:0] i_acc_ptr,
   input wire logic [15:0] i_acc_offset,
   // Result
   output logic o_ea_valid,
   output logic [15:0] o_ea,
   output logic o_wb_en,
   output logic [3:0] o_wb_sel,
   output logic [15:0] o_wb_data
);
   // ==========================================================
   // Registers
   logic [15:0] mode_ctrl_r;
   logic [15:0] xmod_start_r;
   logic [15:0] xmod_end_r;
   logic [15:0] bitrev_mod_r;
   logic [15:0] last_ea_r;
   logic [15:0] rdata_r;

   // Working pointer selects match the access pointer
   function automatic logic sel_match(input logic [3:0] a,
                                      input logic [3:0] b);
      sel_match = (a == b);
   endfunction

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         mode_ctrl_r <= agu_pkg::MODE_RST;
         xmod_start_r <= agu_pkg::XMOD_START_RST;
         xmod_end_r <= agu_pkg::XMOD_END_RST;
         bitrev_mod_r <= agu_pkg::BITREV_RST;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            agu_pkg::ADDR_MODE_CTRL: mode_ctrl_r <= i_reg_wdata;
            agu_pkg::ADDR_XMOD_START: xmod_start_r <= i_reg_wdata;
            agu_pkg::ADDR_XMOD_END: xmod_end_r <= i_reg_wdata;
            agu_pkg::ADDR_BITREV_MOD: bitrev_mod_r <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // Unmapped offsets read as zero
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         rdata_r <= 16'h0000;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            agu_pkg::ADDR_MODE_CTRL: rdata_r <= mode_ctrl_r;
            agu_pkg::ADDR_XMOD_START: rdata_r <= xmod_start_r;
            agu_pkg::ADDR_XMOD_END: rdata_r <= xmod_end_r;
            agu_pkg::ADDR_BITREV_MOD: rdata_r <= bitrev_mod_r;
            agu_pkg::ADDR_LAST_EA: rdata_r <= last_ea_r;
            default: rdata_r <= 16'h0000;
         endcase
      end else begin
         rdata_r <= 16'h0000;
      end
   end
   assign o_reg_rdata = rdata_r;

   // ==========================================================
   // Mode decode
   logic is_pre_inc, is_post_inc, is_pre_dec, is_post_dec, is_ofs;
   logic is_incr, is_decr, is_modify;
   logic [3:0] bitrev_sel;
   logic [3:0] xmod_sel;
   logic xmod_en, bitrev_en;
   logic [14:0] pivot;

   assign is_pre_inc = (i_acc_mode == agu_pkg::AGU_MODE_PRE_INC);
   assign is_post_inc = (i_acc_mode == agu_pkg::AGU_MODE_POST_INC);
   assign is_pre_dec = (i_acc_mode == agu_pkg::AGU_MODE_PRE_DEC);
   assign is_post_dec = (i_acc_mode == agu_pkg::AGU_MODE_POST_DEC);
   assign is_ofs = (i_acc_mode == agu_pkg::AGU_MODE_OFFSET);
   assign is_incr = is_pre_inc | is_post_inc;
   assign is_decr = is_pre_dec | is_post_dec;
   assign is_modify = is_incr | is_decr;
   assign bitrev_sel = mode_ctrl_r[agu_pkg::MODE_BITREV_SEL_LSB +: 4];
   assign xmod_sel = mode_ctrl_r[agu_pkg::MODE_XPTR_SEL_LSB +: 4];
   assign xmod_en = mode_ctrl_r[agu_pkg::MODE_XMOD_EN_BIT];
   assign bitrev_en = bitrev_mod_r[agu_pkg::BITREV_EN_BIT];
   assign pivot = bitrev_mod_r[14:0];

   // ==========================================================
   // Bit reversal qualification
   logic bitrev_act;
   // Select 1111 keeps the stack out of reversal
   // X side writes of words only
   assign bitrev_act = i_acc_xside && i_acc_write && !i_acc_byte &&
                       bitrev_en && is_incr &&
                       (bitrev_sel != agu_pkg::STACK_PTR_SEL) &&
                       sel_match(bitrev_sel, i_acc_ptr_sel);

   // Reference for the ripple adder: reverse, add, reverse back
   function automatic logic [15:0] rev_sum(input logic [15:0] p,
                                           input logic [14:0] q);
      logic [14:0] a;
      logic [14:0] b;
      logic [14:0] t;
      rev_sum = 16'h0000;
      for (int i = 0; i < 15; i++) begin
         a[i] = p[15 - i];
         b[i] = q[14 - i];
      end
      t = 15'(a + b);
      for (int i = 0; i < 15; i++) begin
         rev_sum[15 - i] = t[i];
      end
   endfunction
   logic [15:0] rev_ref;
   assign rev_ref = rev_sum(i_acc_ptr, pivot);

   // ==========================================================
   // Normal step and modulo correction
   logic [15:0] step, modified, raw_ea, mod_in, mod_out, rev_out, ofs_sum;
   logic mod_act;

   always_comb begin
      step = i_acc_byte ? 16'h0001 : 16'h0002;
      modified = i_acc_ptr;
      if (is_incr) begin
         modified = 16'(i_acc_ptr + step);
      end else if (is_decr) begin
         modified = 16'(i_acc_ptr - step);
      end
   end

   // Offset mode corrects the sum, not the pointer
   assign ofs_sum = 16'(i_acc_ptr + i_acc_offset);
   assign mod_in = is_ofs ? ofs_sum : modified;
   // Any working pointer may be selected
   assign mod_act = xmod_en && sel_match(xmod_sel, i_acc_ptr_sel) &&
                    (is_modify || is_ofs);

   agu_modulo u_modulo (
      .i_addr(mod_in),
      .i_incr(mod_act && (is_incr || is_ofs)),
      .i_decr(mod_act && is_decr),
      .i_start(xmod_start_r),
      .i_end(xmod_end_r),
      .o_addr(mod_out)
   );

   // Pivot replaces the mode offset
   agu_bitrev u_bitrev (
      .i_ptr(i_acc_ptr),
      .i_pivot(pivot),
      .o_ptr(rev_out)
   );

   logic [15:0] new_ptr;
   // Bit reversal takes precedence over modulo on writes
   assign new_ptr = bitrev_act ? rev_out :
                    (mod_act ? mod_out : modified);

   always_comb begin
      raw_ea = i_acc_ptr;
      if (is_ofs) begin
         raw_ea = mod_act ? mod_out : ofs_sum;
      end else if (is_pre_inc || is_pre_dec) begin
         raw_ea = new_ptr;
      end
      if (bitrev_act) begin
         raw_ea[0] = 1'b0;
      end
   end

   // ==========================================================
   // Registered result
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_ea_valid <= 1'b0;
         o_ea <= 16'h0000;
         o_wb_en <= 1'b0;
         o_wb_sel <= 4'h0;
         o_wb_data <= 16'h0000;
      end else begin
         o_ea_valid <= i_acc_valid;
         o_ea <= raw_ea;
         o_wb_en <= i_acc_valid && is_modify;
         o_wb_sel <= i_acc_ptr_sel;
         o_wb_data <= new_ptr;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         last_ea_r <= 16'h0000;
      end else if (i_acc_valid) begin
         last_ea_r <= raw_ea;
      end
   end

   // ==========================================================
   // Checks
   // A qualified reversed access and the result it must leave
   sequence s_rev_access;
      i_acc_valid && bitrev_act;
   endsequence

   sequence s_rev_result;
      o_wb_en && (o_wb_data[0] == 1'b0) && (o_ea[0] == 1'b0);
   endsequence

   property p_wb_mode;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_acc_valid && is_ofs) |=> !o_wb_en;
   endproperty
   a_wb_mode: assert property (p_wb_mode)
      else $error("offset wrote back");

   property p_modify_wb;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_acc_valid && is_modify) |=>
      (o_wb_en && (o_wb_sel == $past(i_acc_ptr_sel)));
   endproperty
   a_modify_wb: assert property (p_modify_wb)
      else $error("modify did not write back");

   property p_idle_quiet;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      !i_acc_valid |=> (!o_ea_valid && !o_wb_en);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("result without access");

   property p_stack_norev;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (bitrev_sel == agu_pkg::STACK_PTR_SEL) |-> !bitrev_act;
   endproperty
   a_stack_norev: assert property (p_stack_norev)
      else $error("stack reversed");

   property p_byte_norev;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_acc_byte || !i_acc_write || !i_acc_xside) |-> !bitrev_act;
   endproperty
   a_byte_norev: assert property (p_byte_norev)
      else $error("bad reversal");

   property p_mode_norev;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      !is_incr |-> !bitrev_act;
   endproperty
   a_mode_norev: assert property (p_mode_norev)
      else $error("reversal outside increment modes");

   property p_rev_lsb;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      s_rev_access |=> s_rev_result;
   endproperty
   a_rev_lsb: assert property (p_rev_lsb)
      else $error("reversed lsb set");

   property p_rev_ref;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      s_rev_access |=> (o_wb_data == $past(rev_ref));
   endproperty
   a_rev_ref: assert property (p_rev_ref)
      else $error("reverse carry sum wrong");

   property p_mod_range;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_acc_valid && mod_act && is_incr && !bitrev_act &&
       (modified > xmod_end_r)) |=> (o_wb_data <= xmod_end_r);
   endproperty
   a_mod_range: assert property (p_mod_range)
      else $error("no wrap");

   property p_mod_range_dec;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_acc_valid && mod_act && is_decr &&
       (modified < xmod_start_r)) |=> (o_wb_data >= xmod_start_r);
   endproperty
   a_mod_range_dec: assert property (p_mod_range_dec)
      else $error("no wrap on decrement");

   property p_ofs_ea;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_acc_valid && is_ofs && !mod_act) |=>
      (o_ea == $past(ofs_sum));
   endproperty
   a_ofs_ea: assert property (p_ofs_ea)
      else $error("offset address wrong");

   property p_ofs_wrap;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_acc_valid && is_ofs && mod_act && (ofs_sum > xmod_end_r)) |=>
      (o_ea <= xmod_end_r);
   endproperty
   a_ofs_wrap: assert property (p_ofs_wrap)
      else $error("offset address not wrapped");

   property p_byte_step;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_acc_valid && i_acc_byte && is_incr && !mod_act) |=>
      (o_wb_data == 16'($past(i_acc_ptr) + 16'h0001));
   endproperty
   a_byte_step: assert property (p_byte_step)
      else $error("byte step wrong");

   property p_post_ea;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_acc_valid && (is_post_inc || is_post_dec) && !bitrev_act) |=>
      (o_ea == $past(i_acc_ptr));
   endproperty
   a_post_ea: assert property (p_post_ea)
      else $error("post modify address wrong");

   property p_bitrev_rd;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_reg_rd && (i_reg_addr == agu_pkg::ADDR_BITREV_MOD)) |=>
      (o_reg_rdata == $past(bitrev_mod_r));
   endproperty
   a_bitrev_rd: assert property (p_bitrev_rd)
      else $error("modifier read back wrong");

   property p_last_ea;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      o_ea_valid |-> (last_ea_r == o_ea);
   endproperty
   a_last_ea: assert property (p_last_ea)
      else $error("last address not kept");
endmodule
`default_nettype wire

/* File: agu_pkg.sv */
// Package for the address modification datapath.
// Assumes a 16-bit data address space with byte addressing.
package agu_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [3:0] ADDR_MODE_CTRL = 4'h0;
   localparam logic [3:0] ADDR_XMOD_START = 4'h1;
   localparam logic [3:0] ADDR_XMOD_END = 4'h2;
   localparam logic [3:0] ADDR_BITREV_MOD = 4'h3;
   localparam logic [3:0] ADDR_LAST_EA = 4'h4;
   // ==========================================================
   // Field positions
   localparam int MODE_XMOD_EN_BIT = 15;
   localparam int MODE_BITREV_SEL_LSB = 8;
   localparam int MODE_XPTR_SEL_LSB = 0;
   localparam int BITREV_EN_BIT = 15;
   localparam logic [3:0] STACK_PTR_SEL = 4'hF;
   // ==========================================================
   // Reset values
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] XMOD_START_RST = 16'h0000;
   localparam logic [15:0] XMOD_END_RST = 16'h0001;
   localparam logic [15:0] BITREV_RST = 16'h0000;
   // ==========================================================
   // Addressing modes
   typedef enum logic [2:0] {
      AGU_MODE_DIRECT = 3'h0,
      AGU_MODE_POST_DEC = 3'h1,
      AGU_MODE_POST_INC = 3'h2,
      AGU_MODE_PRE_DEC = 3'h3,
      AGU_MODE_PRE_INC = 3'h4,
      AGU_MODE_OFFSET = 3'h5
   } agu_mode_t;
endpackage

/* File: agu_modulo.sv */
// Modulo boundary correction of one effective address.
// Assumes start <= end and a step no larger than the buffer length.
`timescale 1ns/1ps
`default_nettype none
module agu_modulo (
   // Address in
   input wire logic [15:0] i_addr,
   input wire logic i_incr,
   input wire logic i_decr,
   // Bounds
   input wire logic [15:0] i_start,
   input wire logic [15:0] i_end,
   // Result
   output logic [15:0] o_addr
);
   logic [15:0] len;
   assign len = 16'(i_end - i_start + 16'h0001);
   always_comb begin
      o_addr = i_addr;
      // End is the last valid address; overshoots still wrap
      if (i_incr && (i_addr > i_end)) begin
         o_addr = 16'(i_addr - len);
      end else if (i_decr && (i_addr < i_start)) begin
         o_addr = 16'(i_addr + len);
      end
   end
endmodule
`default_nettype wire

/* File: agu_bitrev.sv */
// Reverse-carry adder for bit-reversed pointer stepping.
// Assumes word data; bit 0 of the result is always clear.
`timescale 1ns/1ps
`default_nettype none
module agu_bitrev (
   // Operands
   input wire logic [15:0] i_ptr,
   input wire logic [14:0] i_pivot,
   // Result
   output logic [15:0] o_ptr
);
   logic [15:0] mod_b;
   logic carry;
   assign mod_b = {i_pivot, 1'b0}; // Byte scaled pivot
   always_comb begin
      carry = 1'b0;
      o_ptr = 16'h0000;
      // Carry ripples from msb toward lsb
      for (int i = 15; i >= 1; i--) begin
         o_ptr[i] = i_ptr[i] ^ mod_b[i] ^ carry;
         carry = (i_ptr[i] & mod_b[i]) | (carry & (i_ptr[i] ^ mod_b[i]));
      end
      o_ptr[0] = 1'b0;
   end
endmodule
`default_nettype wire

/* File: agu_core_model.sv */
// Core-side pointer file that feeds the address modification block.
// Assumes write back arrives one cycle after each access is taken.
`timescale 1ns/1ps
`default_nettype none
module agu_core_model (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // Pointer loads and reads
   input wire logic i_ld,
   input wire logic [3:0] i_ld_sel,
   input wire logic [15:0] i_ld_val,
   input wire logic [3:0] i_rd_sel,
   output logic [15:0] o_ptr,
   // Write back
   input wire logic i_wb_en,
   input wire logic [3:0] i_wb_sel,
   input wire logic [15:0] i_wb_data
);
   logic [15:0] ptr_r [16];
   // ==========================================================
   // Pointer file; write back wins over a load
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ptr_r <= '{default: 16'h0000};
      end else if (i_wb_en) begin
         ptr_r[i_wb_sel] <= i_wb_data;
      end else if (i_ld) begin
         ptr_r[i_ld_sel] <= i_ld_val;
      end
   end
   assign o_ptr = ptr_r[i_rd_sel];
endmodule
`default_nettype wire

/* File: agu_modulo_bitreverse_addressing_tb_top.sv */
// Self-checking bench for the address modification block.
// Assumes the core model holds the pointers the block reads.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin errors++; \
   $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module agu_modulo_bitreverse_addressing_tb_top;
   logic clk = 0, rst = 1, wr = 0, rd = 0, ld = 0, av = 0, xs = 0, aw = 0;
   logic ab = 0, eav, wbe, br_en = 0, x;
   logic [2:0] am = 0, m;
   logic [3:0] ra = 0, ld_sel = 0, sel = 0, wsel, s, mod_sel, br_sel;
   logic [15:0] wd = 0, ld_val = 0, off = 0, rdata, ptr, ea, wdat, v;
   logic [15:0] ms = 16'h1000, me = 16'h100F, last_ea = 16'h0000;
   logic [14:0] piv;
   logic [15:0] rst_v [5] = '{agu_pkg::MODE_RST, agu_pkg::XMOD_START_RST,
      agu_pkg::XMOD_END_RST, agu_pkg::BITREV_RST, 16'h0000};
   int errors = 0, n_checks = 0, cyc = 0, seed = 32'ha0f0;
   agu_addr_mod i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_reg_addr(ra),
      .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .i_acc_valid(av), .i_acc_xside(xs), .i_acc_write(aw), .i_acc_byte(ab),
      .i_acc_mode(am), .i_acc_ptr_sel(sel), .i_acc_ptr(ptr),
      .i_acc_offset(off), .o_ea_valid(eav), .o_ea(ea), .o_wb_en(wbe),
      .o_wb_sel(wsel), .o_wb_data(wdat));
   agu_core_model i_core (.i_ref_clk(clk), .i_sys_rst(rst), .i_ld(ld),
      .i_ld_sel(ld_sel), .i_ld_val(ld_val), .i_rd_sel(sel), .o_ptr(ptr),
      .i_wb_en(wbe), .i_wb_sel(wsel), .i_wb_data(wdat));
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         stop_test();
      end
   end
   // ==========================================================
   // Bus and access tasks
   task automatic stop_test();
      if (errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1;
      ra <= a;
      wd <= d;
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1;
      ra <= a;
      @(posedge clk);
      rd <= 0;
      #1;
      `CHK("rdata", e, rdata)
   endtask
   task automatic ldp(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      ld <= 1;
      ld_sel <= a;
      ld_val <= d;
      @(posedge clk);
      ld <= 0;
   endtask
   // Reverse-carry add of the pointer and the scaled pivot, bit 0 clear
   function automatic logic [15:0] revc(input logic [15:0] p,
      input logic [14:0] q);
      logic [14:0] a, b, t;
      logic [15:0] r;
      for (int i = 0; i < 15; i++) begin
         a[i] = p[15 - i];
         b[i] = q[14 - i];
      end
      t = a + b;
      r = 16'h0000;
      for (int i = 0; i < 15; i++) begin
         r[15 - i] = t[i];
      end
      return r;
   endfunction
   task automatic acc(input logic [2:0] md, input logic [3:0] sl,
      input logic xx, w, b, input logic [15:0] o);
      logic inc, dec, rv;
      logic [15:0] p, n, e;
      @(posedge clk);
      av <= 1;
      am <= md;
      sel <= sl;
      xs <= xx;
      aw <= w;
      ab <= b;
      off <= o;
      #1;
      p = ptr;
      inc = md == agu_pkg::AGU_MODE_POST_INC || md == agu_pkg::AGU_MODE_PRE_INC;
      dec = md == agu_pkg::AGU_MODE_POST_DEC || md == agu_pkg::AGU_MODE_PRE_DEC;
      n = inc ? p + (b ? 16'h0001 : 16'h0002) : p - (b ? 16'h0001 : 16'h0002);
      if (sl == mod_sel && inc && n > me) begin
         n = n - (me - ms + 16'h0001);
      end
      if (sl == mod_sel && dec && n < ms) begin
         n = n + (me - ms + 16'h0001);
      end
      rv = xx && w && !b && inc && br_en && br_sel != 4'hF && sl == br_sel;
      if (rv) begin
         n = revc(p, piv);
      end
      e = (md == agu_pkg::AGU_MODE_PRE_INC || md == agu_pkg::AGU_MODE_PRE_DEC)
         ? n : (md == agu_pkg::AGU_MODE_OFFSET) ? p + o : p;
      // Offset sums wrap upward only; reversed addresses are word aligned
      if (md == agu_pkg::AGU_MODE_OFFSET && sl == mod_sel && e > me) begin
         e = e - (me - ms + 16'h0001);
      end
      e[0] = e[0] & !rv;
      @(posedge clk);
      av <= 0;
      #1;
      `CHK("ea", e, ea)
      `CHK("wb_en", inc || dec, wbe)
      if (inc || dec) begin
         `CHK("wb_data", n, wdat)
         `CHK("wb_sel", sl, wsel)
      end
      `CHK("ea_valid", 1'b1, eav)
      last_ea = e;
      @(posedge clk);
      #1;
      `CHK("ea_valid idle", 1'b0, eav)
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 0;
      #1;
      `CHK("reset outs", 54'h0, {eav, wbe, wsel, ea, wdat, rdata})
      for (int i = 0; i < 5; i++) begin
         rreg(4'(i), rst_v[i]);
      end
      rreg(4'h9, 16'h0000);
      wreg(agu_pkg::ADDR_LAST_EA, 16'hBEEF);
      rreg(agu_pkg::ADDR_LAST_EA, 16'h0000);
      for (int i = 1; i < 4; i++) begin
         v = {15'($random(seed)), i == 2};
         wreg(4'(i), v);
         rreg(4'(i), v);
      end
      // Buffer start aligned to its length
      wreg(agu_pkg::ADDR_XMOD_START, ms);
      wreg(agu_pkg::ADDR_XMOD_END, me);
      for (int k = 0; k < 4; k++) begin
         mod_sel = (k == 1) ? 4'h3 : 4'h2;
         br_sel = (k == 2) ? agu_pkg::STACK_PTR_SEL : 4'h3;
         br_en = (k != 3);
         piv = 15'($random(seed)) & 15'h000F;
         v = {1'b1, 3'h0, br_sel, 4'h0, mod_sel};
         wreg(agu_pkg::ADDR_MODE_CTRL, v);
         rreg(agu_pkg::ADDR_MODE_CTRL, v);
         wreg(agu_pkg::ADDR_BITREV_MOD, {br_en, piv});
         // Idle cycle before using the reversed pointer
         @(posedge clk);
         for (int j = 0; j < 40; j++) begin
            s = ($random(seed) & 4) ? 4'hF : 4'($random(seed) & 3);
            ldp(s, 16'h0FF8 + 16'($random(seed) & 31));
            m = 3'($unsigned($random(seed)) % 5);
            x = 1'($random(seed)) | (s == mod_sel);
            acc(m, s, x, 1'($random(seed)), 1'($random(seed)), 16'h0000);
         end
      end
      ldp(mod_sel, 16'h1002);
      acc(agu_pkg::AGU_MODE_OFFSET, mod_sel, 1'b1, 1'b1, 1'b0, 16'h0004);
      ldp(mod_sel, 16'h100C);
      acc(agu_pkg::AGU_MODE_OFFSET, mod_sel, 1'b1, 1'b1, 1'b0, 16'h0008);
      ldp(4'h1, 16'h2000);
      acc(agu_pkg::AGU_MODE_OFFSET, 4'h1, 1'b1, 1'b0, 1'b0, 16'h0010);
      rreg(agu_pkg::ADDR_LAST_EA, last_ea);
      stop_test();
   end
endmodule
`default_nettype wire
